// >>> hw/bus_cycle_consts.svh
/*
 * Constants of the local bus cycle unit: status codes, timing figures.
 * Assumes a 200 MHz system clock; included by the unit, clock, checker and bench files, not the package.
 */
// Summary of operation
// - Every cycle opens with a latch strobe pulse
// - Memory-select low: eight memory cycle codes
// - Memory-select high: eight internal cycle codes
// - Workspace pointer update drives new pointer
// - Flags update drives bits 7-11 first
// - Macro-detect samples present input when ready
// - Fetch may precede prior result store
// - Direction low on write, high on read
// - Read strobe low after latch only reading
// - After latch drive write data or float
// - Code, direction, select stable whole cycle
// - Internal cycles other than I/O and emulation: strobes high, direction low
// - One state is one output clock period
// - Ready low adds whole wait states
// - Emulation-code internal cycles pulse a strobe
// - I/O cycles last at least two states
// - Write: latch, address, select, then data, strobe
// - Read: address, latch falls, float, read strobe
// - Page select and code on every memory cycle
// - Ready sampled at output clock falling edge
// - Page select is inverse of status bit 8
`ifndef BUS_CYCLE_CONSTS_SVH
`define BUS_CYCLE_CONSTS_SVH

// Codes with memory select low
`define CODE_SRC_LOCKED   3'h0
`define CODE_SRC          3'h1
`define CODE_IMMEDIATE    3'h2
`define CODE_FETCH        3'h3
`define CODE_DEST         3'h4
`define CODE_INT_ACK      3'h5
`define CODE_WORKSPACE    3'h6
`define CODE_GEN_MEM      3'h7
// Codes with memory select high
`define CODE_ALU_LOCKED   3'h0
`define CODE_ALU          3'h1
`define CODE_RESET        3'h2
`define CODE_IO           3'h3
`define CODE_WP_UPDATE    3'h4
`define CODE_FLAGS_UPDATE 3'h5
`define CODE_MACRO_DET    3'h6
`define CODE_HOLD_GRANT   3'h7

// Flag field placed on the lines during a flags update
`define FLAGS_LO_BIT      7
`define FLAGS_HI_BIT      11
`define PAGE_FLAG_BIT     8

// Least cycle lengths in machine states
`define MIN_STATES_MEM    3'h1
`define MIN_STATES_IO     3'h2

// Output clock half period: 2 system clocks, so one state is 20 ns
`define HALF_PERIOD_NS    10
`define SYS_PERIOD_NS     5
`define HALF_PERIOD_CYC   (`HALF_PERIOD_NS / `SYS_PERIOD_NS)

`endif

// >>> hw/bus_cycle_pkg.sv
/*
 * Types of the local bus cycle unit.
 * Assumes bus_cycle_consts.svh for the numeric values.
 */
package bus_cycle_pkg;

    // ========================================================
    // Cycle request from the core
    typedef struct packed {
        logic        mem_n;      // Memory-cycle select level
        logic [2:0]  code;       // Bus state code
        logic        read;       // Transfer direction
        logic [15:0] addr;       // Byte address or pointer
        logic [15:0] wdata;      // Write word
        logic        page_flag;  // Status bit 8
        logic [4:0]  flags;      // Status bits 7..11
    } cycle_req_t;

    // ========================================================
    // Bus pin group
    typedef struct packed {
        logic        addr_latch_strobe;
        logic        mem_n;
        logic [2:0]  bus_state_code;
        logic        rd_wr_n;
        logic        read_strobe_n;
        logic        write_strobe_io_clock_n;
        logic        page_select_n;
        logic [15:0] ad_out;
        logic        ad_oe;
    } bus_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LATCH = 3'b001,
        ST_DATA  = 3'b010,
        ST_DONE  = 3'b011
    } seq_state_t;

endpackage

// >>> hw/state_clock_gen.sv
/*
 * Machine state clock divider: output clock plus phase strobes.
 * Assumes a free running system clock; half period from the header.
 */
`timescale 1ns/1ps
`include "bus_cycle_consts.svh"

module state_clock_gen #(
    parameter int unsigned HALF = `HALF_PERIOD_CYC
) (
    input  wire logic clk,       // System clock
    input  wire logic sys_rst,   // Async reset, high
    output logic      clk_out,   // Machine state clock
    output logic      rise_tick, // Pulse: state begins next edge
    output logic      fall_tick  // Pulse: mid-state edge next edge
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_q, cnt_d;
    logic          clk_q, clk_d;

    // ========================================================
    // Divider
    always_comb begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        clk_d = (cnt_q == LAST) ? ~clk_q : clk_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign clk_out   = clk_q;
    assign rise_tick = (cnt_q == LAST) && !clk_q;
    assign fall_tick = (cnt_q == LAST) && clk_q;
endmodule

// >>> hw/bus_cycle_unit.sv
/*
 * Local bus cycle sequencer: drives the multiplexed address/data bus,
 * the strobes and status outputs for one cycle request at a time.
 * Assumes the core holds a request until cycle_done, inputs are
 * synchronous to clk, and the pad ring resolves ad_out/ad_oe.
 */
`timescale 1ns/1ps
`include "bus_cycle_consts.svh"

module bus_cycle_unit #(
    parameter int unsigned AW = 16
) (
    input  wire logic                        clk,          // 200 MHz
    input  wire logic                        sys_rst,      // Async high
    input  wire logic                        req_valid,    // Cycle wanted
    output logic                             req_ready,    // Taken now
    input  wire bus_cycle_pkg::cycle_req_t   req,          // Request
    output logic                             cycle_done,   // End pulse
    output logic [AW-1:0]                    read_data,    // Read word
    output logic                             app_sampled,  // Present seen
    output logic                             app_present,  // Captured
    input  wire logic                        ready,        // Wait input
    input  wire logic                        attached_proc_present_n, // In
    input  wire logic [AW-1:0]               ad_in,        // Bus in
    output logic [AW-1:0]                    ad_out,       // Bus out
    output logic                             ad_oe,        // Bus drive
    output logic                             addr_latch_strobe, // Latch
    output logic                             mem_n,        // Mem select
    output logic [2:0]                       bus_state_code, // Code
    output logic                             rd_wr_n,      // Direction
    output logic                             read_strobe_n, // Read
    output logic                             write_strobe_io_clock_n, // Wr
    output logic                             page_select_n, // Page
    output logic                             machine_state_clock_out // Clk
);
    logic rise_tick, fall_tick;

    state_clock_gen u_clk (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_out   (machine_state_clock_out),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick)
    );

    // ========================================================
    // Cycle classification from the latched request
    bus_cycle_pkg::cycle_req_t  cur_q, cur_d;
    bus_cycle_pkg::seq_state_t  st_q, st_d;
    bus_cycle_pkg::bus_pins_t   pins_q, pins_d;
    logic [2:0]                 states_q, states_d;
    logic                       ready_q, ready_d;
    logic [AW-1:0]              rdata_q, rdata_d;
    logic                       done_q, done_d;
    logic                       apps_q, apps_d;
    logic                       appv_q, appv_d;

    logic is_io, is_emul, transfers, xfer_read, min_met;

    always_comb begin
        is_io   = cur_q.mem_n && (cur_q.code == `CODE_IO);
        is_emul = cur_q.mem_n && ((cur_q.code == `CODE_ALU_LOCKED) ||
                                  (cur_q.code == `CODE_ALU));
        // Memory cycles, I/O and emulation accesses move data
        transfers = !cur_q.mem_n || is_io || is_emul;
        xfer_read = transfers && cur_q.read;
        min_met = (states_q >= (is_io ? `MIN_STATES_IO
                                      : `MIN_STATES_MEM));
    end

    // Address phase contents depend on the code
    function automatic logic [AW-1:0] addr_phase(
        input bus_cycle_pkg::cycle_req_t r);
        logic [AW-1:0] a;
        a = r.addr;
        if (r.mem_n && r.code == `CODE_FLAGS_UPDATE) begin
            a = '0;
            a[`FLAGS_HI_BIT:`FLAGS_LO_BIT] = r.flags;
        end
        return a;
    endfunction

    // ========================================================
    // Sequencer
    always_comb begin
        st_d     = st_q;
        cur_d    = cur_q;
        pins_d   = pins_q;
        states_d = states_q;
        ready_d  = ready_q;
        rdata_d  = rdata_q;
        done_d   = 1'b0;
        apps_d   = 1'b0;
        appv_d   = appv_q;
        req_ready = 1'b0;
        unique case (st_q)
            bus_cycle_pkg::ST_IDLE: begin
                // Starting only at a state boundary keeps whole states
                if (req_valid && rise_tick) begin
                    req_ready = 1'b1;
                    cur_d = req;
                    st_d  = bus_cycle_pkg::ST_LATCH;
                    states_d = 3'h1;
                    pins_d.addr_latch_strobe = 1'b1;
                    pins_d.mem_n = req.mem_n;
                    pins_d.bus_state_code = req.code;
                    // Internal cycles other than I/O and emulation go low
                    pins_d.rd_wr_n = req.read &&
                        (!req.mem_n || (req.code == `CODE_IO) ||
                         (req.code == `CODE_ALU_LOCKED) ||
                         (req.code == `CODE_ALU));
                    pins_d.page_select_n = ~req.page_flag;
                    pins_d.ad_out = addr_phase(req);
                    pins_d.ad_oe  = 1'b1;
                    pins_d.read_strobe_n = 1'b1;
                    pins_d.write_strobe_io_clock_n = 1'b1;
                end
            end
            bus_cycle_pkg::ST_LATCH: begin
                // Latch strobe high for the first half of the state
                if (fall_tick) begin
                    pins_d.addr_latch_strobe = 1'b0;
                    ready_d = ready;
                    if (xfer_read) begin
                        pins_d.ad_oe = 1'b0;
                        pins_d.read_strobe_n = 1'b0;
                    end else if (transfers) begin
                        pins_d.ad_out = cur_q.wdata;
                        pins_d.write_strobe_io_clock_n = 1'b0;
                    end else begin
                        pins_d.ad_oe = 1'b0;
                    end
                    st_d = bus_cycle_pkg::ST_DATA;
                end
            end
            bus_cycle_pkg::ST_DATA: begin
                if (fall_tick) begin
                    ready_d = ready;
                end
                if (rise_tick) begin
                    if (ready_q && min_met) begin
                        st_d = bus_cycle_pkg::ST_DONE;
                        if (xfer_read) begin
                            rdata_d = ad_in;
                        end
                        if (cur_q.mem_n &&
                            cur_q.code == `CODE_MACRO_DET) begin
                            apps_d = 1'b1;
                            appv_d = ~attached_proc_present_n;
                        end
                    end else begin
                        // Code, select, direction held unchanged
                        states_d = (states_q == 3'h7) ? states_q
                                   : states_q + 3'h1;
                    end
                end
            end
            bus_cycle_pkg::ST_DONE: begin
                // Strobes release one system clock after the state boundary; next cycle
                // may begin on the following boundary. Fetches may
                // be requested ahead of stores by the core.
                pins_d.read_strobe_n = 1'b1;
                pins_d.write_strobe_io_clock_n = 1'b1;
                pins_d.ad_oe = 1'b0;
                done_d = 1'b1;
                st_d = bus_cycle_pkg::ST_IDLE;
            end
            default: st_d = bus_cycle_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q     <= bus_cycle_pkg::ST_IDLE;
            cur_q    <= '0;
            pins_q   <= '{addr_latch_strobe: 1'b0, mem_n: 1'b1,
                          bus_state_code: 3'h7, rd_wr_n: 1'b1,
                          read_strobe_n: 1'b1,
                          write_strobe_io_clock_n: 1'b1,
                          page_select_n: 1'b1, ad_out: 16'h0000,
                          ad_oe: 1'b0};
            states_q <= 3'h0;
            ready_q  <= 1'b1;
            rdata_q  <= '0;
            done_q   <= 1'b0;
            apps_q   <= 1'b0;
            appv_q   <= 1'b0;
        end else begin
            st_q     <= st_d;
            cur_q    <= cur_d;
            pins_q   <= pins_d;
            states_q <= states_d;
            ready_q  <= ready_d;
            rdata_q  <= rdata_d;
            done_q   <= done_d;
            apps_q   <= apps_d;
            appv_q   <= appv_d;
        end
    end

    // ========================================================
    // Outputs
    assign ad_out                  = pins_q.ad_out;
    assign ad_oe                   = pins_q.ad_oe;
    assign addr_latch_strobe       = pins_q.addr_latch_strobe;
    assign mem_n                   = pins_q.mem_n;
    assign bus_state_code          = pins_q.bus_state_code;
    assign rd_wr_n                 = pins_q.rd_wr_n;
    assign read_strobe_n           = pins_q.read_strobe_n;
    assign write_strobe_io_clock_n = pins_q.write_strobe_io_clock_n;
    assign page_select_n           = pins_q.page_select_n;
    assign cycle_done              = done_q;
    assign read_data               = rdata_q;
    assign app_sampled             = apps_q;
    assign app_present             = appv_q;
endmodule

// >>> verification/bus_cycle_checker.sv
/*
 * Port checker for the local bus cycle unit, bound into every instance.
 * Assumes the core holds req unchanged from request until cycle_done.
 */
`timescale 1ns/1ps
`include "bus_cycle_consts.svh"

module bus_cycle_checker #(
    parameter int unsigned AW = 16 // Bus width
) (
    input wire logic                      clk,               // Clock
    input wire logic                      sys_rst,           // Reset
    input wire bus_cycle_pkg::cycle_req_t req,               // Request
    input wire logic                      cycle_done,        // End
    input wire logic [AW-1:0]             ad_out,            // Bus out
    input wire logic                      ad_oe,             // Drive
    input wire logic                      addr_latch_strobe, // Latch
    input wire logic                      mem_n,             // Select
    input wire logic [2:0]                bus_state_code,    // Code
    input wire logic                      rd_wr_n,           // Direction
    input wire logic                      read_strobe_n,     // Read
    input wire logic                      write_strobe_io_clock_n, // Wr
    input wire logic                      page_select_n,     // Page
    input wire logic                      machine_state_clock_out // Out
);
    // ==========================================================
    // Cycle tracking
    logic       cyc_d;
    logic       cyc_q;
    logic [7:0] len_d;
    logic [7:0] len_q;
    logic       int_c;

    always_comb begin
        cyc_d = addr_latch_strobe | (cyc_q & ~cycle_done);
        len_d = addr_latch_strobe ? 8'h00 : len_q + 8'h01;
        // Hold grant floats the bus, so it is left out here
        int_c = mem_n & (bus_state_code >= `CODE_RESET)
              & (bus_state_code != `CODE_IO)
              & (bus_state_code != `CODE_HOLD_GRANT);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_q <= 1'b0;
            len_q <= 8'h00;
        end else begin
            cyc_q <= cyc_d;
            len_q <= len_d;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence open_s;
        $rose(addr_latch_strobe);
    endsequence
    sequence data_s;
        $fell(addr_latch_strobe);
    endsequence

    latch_pulse_a: assert property (
        open_s |-> ##[1:4] !addr_latch_strobe) else $error("latch too long");
    code_match_a: assert property (
        addr_latch_strobe |-> mem_n == req.mem_n
            && bus_state_code == req.code) else $error("bus code wrong");
    update_addr_a: assert property (
        addr_latch_strobe && mem_n && bus_state_code[2:1] == 2'h2 |->
            (bus_state_code == `CODE_WP_UPDATE ? ad_out == req.addr
            : ad_out[`FLAGS_HI_BIT:`FLAGS_LO_BIT] == req.flags))
        else $error("update value wrong");
    dir_mem_a: assert property (
        addr_latch_strobe && !mem_n |-> rd_wr_n == req.read)
        else $error("direction wrong");
    read_only_a: assert property (
        !read_strobe_n |-> rd_wr_n && !addr_latch_strobe)
        else $error("read strobe misplaced");
    float_read_a: assert property (
        data_s ##0 rd_wr_n |-> ##[0:2] !ad_oe) else $error("bus not floated");
    write_data_a: assert property (
        data_s ##0 (!rd_wr_n && !mem_n) |->
            ##[0:2] (ad_oe && ad_out == req.wdata))
        else $error("no write data");
    hold_status_a: assert property (
        cyc_q && !addr_latch_strobe |->
            $stable({mem_n, bus_state_code, rd_wr_n}))
        else $error("status moved");
    quiet_int_a: assert property (
        cyc_q && int_c |->
            read_strobe_n && write_strobe_io_clock_n && !rd_wr_n)
        else $error("internal cycle strobed");
    min_len_a: assert property (
        cycle_done && cyc_q |-> len_q >=
            ((mem_n && bus_state_code == `CODE_IO) ? 8'h05 : 8'h01))
        else $error("cycle too short");
    page_sel_a: assert property (
        addr_latch_strobe && !mem_n |-> page_select_n == !req.page_flag)
        else $error("page select wrong");
    // Half period of the state clock is two system clocks
    state_clock_a: assert property (
        $rose(machine_state_clock_out) |-> ##2 $fell(machine_state_clock_out)
            ##2 $rose(machine_state_clock_out))
        else $error("state clock period wrong");
    start_edge_a: assert property (
        open_s |-> $rose(machine_state_clock_out))
        else $error("cycle starts off a state boundary");
endmodule

bind bus_cycle_unit bus_cycle_checker #(.AW(AW)) chk_u (.*);

// >>> verification/mem_partner.sv
/*
 * Memory and ready logic model facing the bus cycle unit.
 * Assumes the bench sets the wait count before each cycle opens.
 */
`timescale 1ns/1ps

module mem_partner (
    input  wire logic        clk,                     // Clock
    input  wire logic        addr_latch_strobe,       // Latch
    input  wire logic        read_strobe_n,           // Read
    input  wire logic        write_strobe_io_clock_n, // Write
    input  wire logic [15:0] ad_out,                  // Bus out
    input  wire logic        ad_oe,                   // Drive
    input  wire logic [3:0]  waits,                   // Wait states
    output logic             ready,                   // Ready
    output logic [15:0]      ad_in                    // Bus in
);
    // ==========================================================
    // Storage and wait counter
    logic [15:0] mem [0:255];
    logic [15:0] addr_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [5:0]  wcnt_q = 6'h00;
    logic        lat_q  = 1'b0;

    assign ready = (wcnt_q == 6'h00);
    // A released bus shows the inverse of the last word, not stale data
    assign ad_in = read_strobe_n ? ~last_q : mem[addr_q[8:1]];

    always @(posedge clk) begin
        lat_q <= addr_latch_strobe;
        if (addr_latch_strobe)
            addr_q <= ad_out;
        // One state is four clocks; low spans waits whole states.
        // Loaded as the latch rises, so the first sample already sees it
        if (addr_latch_strobe && !lat_q)
            wcnt_q <= {waits, 2'b00};
        else if (wcnt_q != 6'h00)
            wcnt_q <= wcnt_q - 6'h01;
        if (!write_strobe_io_clock_n && ad_oe)
            mem[addr_q[8:1]] <= ad_out;
        if (!read_strobe_n)
            last_q <= mem[addr_q[8:1]];
    end
endmodule

// >>> verification/tb_top.sv
/*
 * Testbench of the bus cycle unit with a memory model on its bus.
 * Assumes the unit takes one request at a time and ends it by cycle_done.
 */
`timescale 1ns/1ps
`include "bus_cycle_consts.svh"

module tb_top;
    logic                      clk = 1'b0;
    logic                      sys_rst;
    logic                      req_valid;
    bus_cycle_pkg::cycle_req_t req;
    logic                      ready;
    logic                      attached_proc_present_n;
    logic [3:0]                waits;
    logic [15:0]               ad_in, ad_out, read_data;
    logic                      req_ready, cycle_done, app_sampled;
    logic                      app_present, ad_oe, addr_latch_strobe;
    logic                      mem_n, rd_wr_n, read_strobe_n, page_select_n;
    logic                      write_strobe_io_clock_n;
    logic                      machine_state_clock_out;
    logic [2:0]                bus_state_code;
    int                        mismatches = 0;
    int                        total_checks = 0;
    int                        len;
    logic                      saw_rd, saw_wr, saw_app;

    bus_cycle_unit dut_u (.*);
    mem_partner    far_u (.*);

    always #2.5 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic check_val(input string what, input logic [15:0] exp,
                             input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic run_cycle(input logic m, input logic [2:0] c,
                             input logic rd, input logic [15:0] a,
                             input logic [15:0] d, input logic [3:0] w);
        int n;
        n = 0;
        waits <= w;
        req <= '{mem_n: m, code: c, read: rd, addr: a, wdata: d,
                 page_flag: a[0], flags: a[4:0]};
        req_valid <= 1'b1;
        saw_rd = 1'b0;
        saw_wr = 1'b0;
        saw_app = 1'b0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        len = 0;
        while (cycle_done !== 1'b1 && len < 400) begin
            @(posedge clk);
            len++;
            if (read_strobe_n === 1'b0) saw_rd = 1'b1;
            if (write_strobe_io_clock_n === 1'b0) saw_wr = 1'b1;
            if (app_sampled === 1'b1) saw_app = 1'b1;
        end
        check_val("cycle end", 16'h0001, {15'h0, cycle_done});
    endtask

    task automatic end_of_test;
        $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic write_read_test;
        run_cycle(1'b0, `CODE_DEST, 1'b0, 16'h1234, 16'ha5c3, 4'h0);
        check_val("write strobes", 16'h0001, {14'h0, saw_rd, saw_wr});
        run_cycle(1'b0, `CODE_GEN_MEM, 1'b1, 16'h1234, 16'h0000, 4'h0);
        check_val("read word", 16'ha5c3, read_data);
        check_val("read strobes", 16'h0002, {14'h0, saw_rd, saw_wr});
    endtask

    task automatic wait_test;
        int base;
        run_cycle(1'b0, `CODE_SRC, 1'b1, 16'h1234, 16'h0000, 4'h0);
        base = len;
        run_cycle(1'b0, `CODE_SRC, 1'b1, 16'h1234, 16'h0000, 4'h3);
        check_val("wait length", 16'(base + 12), 16'(len));
        check_val("waited word", 16'ha5c3, read_data);
    endtask

    task automatic code_test;
        int base;
        run_cycle(1'b0, `CODE_FETCH, 1'b1, 16'h1234, 16'h0000, 4'h0);
        base = len;
        for (int c = 0; c < 8; c++) begin
            run_cycle(1'b0, 3'(c), 1'b1, 16'h1234 | 16'(c & 1), 16'h0000,
                      4'h1);
            check_val("mem code word", 16'ha5c3, read_data);
        end
        // Hold grant is left out: it hands the bus away
        for (int c = 0; c < 7; c++) begin
            run_cycle(1'b1, 3'(c), 1'b1, 16'h1234 | 16'(c & 1), 16'h0000,
                      4'(c < 2));
            if (c < 2)
                check_val("emu word", 16'ha5c3, read_data);
            else if (c != 3)
                check_val("int strobes", 16'h0000,
                          {14'h0, saw_rd, saw_wr});
            else
                check_val("io length", 16'h0001,
                          {15'h0, len >= base + 4});
            if (c == 6)
                check_val("present", 16'h0003,
                          {14'h0, saw_app, app_present});
        end
        // Second detect cycle with no attached processor on the bus
        attached_proc_present_n <= 1'b1;
        run_cycle(1'b1, `CODE_MACRO_DET, 1'b1, 16'h1234, 16'h0000,
                  4'h0);
        check_val("absent", 16'h0002, {14'h0, saw_app, app_present});
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        waits = 4'h0;
        attached_proc_present_n = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        write_read_test;
        wait_test;
        code_test;
        end_of_test;
    end

    // About 21 cycles of some 11 clocks each; forty times that is ample
    initial begin
        #50000;
        mismatches++;
        end_of_test;
    end
endmodule
